//--- include/comparator_control_map.svh
// register map, field positions and reset values of the comparator control block
//
// Overview of operation
// - standby_run set keeps comparator running in standby; clear halts it there
// - in standby without clock, flag and state bit stay frozen and the interrupt is held low
// - pad_output_en routes comparator output to pin; clear withholds it
// - edge_select: 0 any edge, 2 falling, 3 rising, 1 reserved
// - low_current_sel drives the analog core's reduced-current control
// - hysteresis_sel bits 2:1 passed to analog core: off, 10, 25, 50 mV
// - control bit 0 enables comparator; zero keeps it disabled
// - invert bit inverts output for pad, events, state bit and edges
// - positive_input_sel bit 3 picks positive pin zero or one
// - negative_input_sel picks pin zero, pin one, reference or converter output
// - interrupt_enable bit 0 at offset 0x06 enables the interrupt request
// - status bit 4 shows synchronised output, visible three cycles after change
// - status bit 0 is the flag; write one clears, zero ignored
// - mux register at 0x02 resets zero; only bits 7,3,1,0 exist
// - interrupt asserted while flag, enable and mask bit (0x08) set outside clockless standby, until flag cleared
// - while the core runs, output drives the event network continuously
// - power-down sleep disables comparator and pad output regardless
`ifndef COMPARATOR_CONTROL_MAP_SVH
`define COMPARATOR_CONTROL_MAP_SVH

// ----------------------------------------------------------------------
// register word indices; the byte address is four times the index, and
// each register sits in the low byte of its own word
// ----------------------------------------------------------------------
`define CMP_OFS_CONTROL 8'h00
`define CMP_OFS_MUX 8'h02
`define CMP_OFS_INT_EN 8'h06
`define CMP_OFS_STATUS 8'h07
`define CMP_OFS_INT_MASK 8'h08
`define CMP_OFS_MASK_BITS 8'h03

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CMP_BIT_ENABLE 0
`define CMP_BIT_LOW_CURRENT 3
`define CMP_BIT_PAD_OUT 6
`define CMP_BIT_STANDBY_RUN 7
`define CMP_BIT_INVERT 7
`define CMP_BIT_POS_SEL 3
`define CMP_BIT_IRQ 0
`define CMP_BIT_STATE 4
`define CMP_MUX_IMPL_MASK 8'h8b
`define CMP_RESET_BYTE 8'h00
`define CMP_SYNC_STAGES 3

`endif

//--- include/comparator_control_pkg.sv
// types shared by the comparator control block
package comparator_control_pkg;

    typedef enum logic [1:0] {
        ANY_EDGE = 2'b00,
        EDGE_RESERVED = 2'b01,
        FALLING_EDGE = 2'b10,
        RISING_EDGE = 2'b11
    } edge_select_t;

    typedef enum logic [1:0] {
        SLEEP_ACTIVE = 2'b00,
        SLEEP_IDLE = 2'b01,
        SLEEP_STANDBY = 2'b10,
        SLEEP_POWER_DOWN = 2'b11
    } sleep_mode_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ
    } bus_phase_t;

    typedef struct packed {
        logic standby_run;
        logic pad_output_en;
        logic [1:0] edge_select;
        logic low_current_sel;
        logic [1:0] hysteresis_sel;
        logic enable;
    } control_reg_t;

    typedef struct packed {
        control_reg_t control;
        logic invert;
        logic positive_input_sel;
        logic [1:0] negative_input_sel;
        logic irq_enable;
        logic compare_irq;
        logic irq_mask;
        logic [2:0] sync;
        logic prev_sample;
        logic prev_valid;
        bus_phase_t phase;
        logic [7:0] addr;
        logic [31:0] rdata;
    } state_t;

endpackage : comparator_control_pkg

//--- rtl/comparator_control_regs.sv
// comparator control and status registers behind an AHB-Lite slave
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "comparator_control_map.svh"

module comparator_control_regs #(
    parameter int SYNC_STAGES = `CMP_SYNC_STAGES
) (
    input wire logic core_clk, // 25 MHz peripheral clock
    input wire logic rst_b, // asynchronous reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic hreadyout, // slave ready out
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic comp_raw, // raw analog comparator output
    input wire comparator_control_pkg::sleep_mode_t sleep_mode, // sleep state
    input wire logic clk_per_running, // peripheral clock requested
    output logic comp_enable, // analog core enable
    output logic low_current_sel, // reduced-current control
    output logic [1:0] hysteresis_sel, // hysteresis level
    output logic positive_input_sel, // positive mux select
    output logic [1:0] negative_input_sel, // negative mux select
    output logic pad_out, // pin data
    output logic pad_out_oe_b, // pin drive enable, low drives
    output logic event_out, // event network output
    output logic irq // level interrupt
);
    import comparator_control_pkg::*;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (SYNC_STAGES != 3) begin : g_bad_sync
        $error("synchroniser depth must be three");
    end

    state_t s_q;
    state_t s_d;
    logic running;
    logic clock_live;
    logic polar_out;
    logic sampled;
    logic edge_hit;
    logic bus_take;
    logic [7:0] wbyte;
    logic [7:0] status_byte;

    // register byte selected by its word index; upper bits read zero
    function automatic logic [7:0] reg_read(input state_t s,
                                            input logic [7:0] a);
        logic [7:0] v;
        v = `CMP_RESET_BYTE;
        case (a)
            `CMP_OFS_CONTROL: v = s.control;
            `CMP_OFS_MUX: v = {s.invert, 3'b000, s.positive_input_sel,
                               1'b0, s.negative_input_sel};
            `CMP_OFS_INT_EN: v = {7'b000_0000, s.irq_enable};
            `CMP_OFS_STATUS: v = {3'b000, s.sync[2], 3'b000, s.compare_irq};
            `CMP_OFS_INT_MASK: v = {7'b000_0000, s.irq_mask};
            default: v = `CMP_RESET_BYTE;
        endcase
        return v;
    endfunction : reg_read

    // ------------------------------------------------------------------
    // comparator path
    // ------------------------------------------------------------------
    // the core runs when enabled, except standby without standby_run and
    // always off in power-down
    always_comb begin
        running = s_q.control.enable;
        if (sleep_mode == SLEEP_POWER_DOWN) begin
            running = 1'b0;
        end else if (sleep_mode == SLEEP_STANDBY) begin
            running = s_q.control.enable & s_q.control.standby_run;
        end
        // in standby the peripheral clock may be gone; freeze status
        clock_live = (sleep_mode != SLEEP_STANDBY) | clk_per_running;
    end

    assign polar_out = comp_raw ^ s_q.invert;
    assign sampled = s_q.sync[2];
    assign comp_enable = running;
    assign low_current_sel = s_q.control.low_current_sel;
    assign hysteresis_sel = s_q.control.hysteresis_sel;
    assign positive_input_sel = s_q.positive_input_sel;
    assign negative_input_sel = s_q.negative_input_sel;
    // pad and event are fed straight from the core, so they keep moving
    // in standby even when the status logic is frozen
    assign pad_out = polar_out & running & s_q.control.pad_output_en;
    assign pad_out_oe_b = ~(running & s_q.control.pad_output_en);
    assign event_out = polar_out & running;

    // edge match on consecutive synchronised samples
    always_comb begin
        edge_hit = 1'b0;
        if (s_q.prev_valid && (sampled != s_q.prev_sample)) begin
            case (edge_select_t'(s_q.control.edge_select))
                ANY_EDGE: edge_hit = 1'b1;
                FALLING_EDGE: edge_hit = ~sampled;
                RISING_EDGE: edge_hit = sampled;
                default: edge_hit = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // bus slave and next state
    // ------------------------------------------------------------------
    assign bus_take = hsel & hready & htrans[1];
    // every register takes the low byte of a whole aligned word
    assign wbyte = hwdata[7:0];

    always_comb begin
        s_d = s_q;
        s_d.rdata = 32'h0000_0000;
        // address phase: capture request, zero wait states
        s_d.phase = BUS_IDLE;
        if (bus_take) begin
            s_d.phase = hwrite ? BUS_WRITE : BUS_READ;
            // word index; byte lane bits are ignored for whole words
            s_d.addr = haddr[9:2];
            if (!hwrite) begin
                s_d.rdata = {24'h00_0000, reg_read(s_q, haddr[9:2])};
            end
        end
        // synchroniser and edge history advance only with a live clock
        if (clock_live) begin
            s_d.sync = {s_q.sync[1:0], polar_out & running};
            s_d.prev_sample = sampled;
            s_d.prev_valid = running;
        end
        // data phase of a write
        if (s_q.phase == BUS_WRITE) begin
            case (s_q.addr)
                `CMP_OFS_CONTROL: s_d.control = control_reg_t'(wbyte);
                `CMP_OFS_MUX: begin
                    s_d.invert = wbyte[`CMP_BIT_INVERT];
                    s_d.positive_input_sel = wbyte[`CMP_BIT_POS_SEL];
                    s_d.negative_input_sel = wbyte[1:0];
                end
                `CMP_OFS_INT_EN: s_d.irq_enable = wbyte[`CMP_BIT_IRQ];
                `CMP_OFS_STATUS: begin
                    if (wbyte[`CMP_BIT_IRQ]) begin
                        s_d.compare_irq = 1'b0;
                    end
                end
                `CMP_OFS_INT_MASK: s_d.irq_mask = wbyte[`CMP_BIT_IRQ];
                default: s_d.irq_mask = s_q.irq_mask;
            endcase
        end
        // hardware set wins over a clear in the same cycle
        if (clock_live && edge_hit) begin
            s_d.compare_irq = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign status_byte = reg_read(s_q, `CMP_OFS_STATUS);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = (s_q.phase == BUS_READ) ? s_q.rdata : 32'h0000_0000;
    // irq needs the documented enable and the extra mask register both
    assign irq = status_byte[`CMP_BIT_IRQ] & s_q.irq_enable
                 & s_q.irq_mask & clock_live;

endmodule : comparator_control_regs
`default_nettype wire

//--- sim/comparator_control_assertions.sv
// concurrent checks on the comparator control block ports
`timescale 1ns/1ps
`default_nettype none
module comparator_control_assertions (
    input wire logic core_clk, // clock
    input wire logic rst_b, // reset, active low
    input wire logic hsel, // slave select
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic hready, // bus ready
    input wire logic [31:0] hrdata, // read data
    input wire comparator_control_pkg::sleep_mode_t sleep_mode, // sleep
    input wire logic clk_per_running, // clock request
    input wire logic comp_enable, // core enable
    input wire logic low_current_sel, // low current
    input wire logic [1:0] hysteresis_sel, // hysteresis
    input wire logic positive_input_sel, // positive mux
    input wire logic [1:0] negative_input_sel, // negative mux
    input wire logic pad_out, // pin data
    input wire logic pad_out_oe_b, // pin enable, low drives
    input wire logic event_out, // event output
    input wire logic irq // interrupt
);
    import comparator_control_pkg::*;
    logic wr_q; // last address phase was a write
    logic rd_q; // last address phase was a read
    // ------------------------------------------------------------------
    // helper logic and properties
    // ------------------------------------------------------------------
    // registers only change a data phase after a write was taken
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            rd_q <= hsel && hready && htrans[1] && !hwrite;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    a_event_gated: assert property (!comp_enable |-> !event_out)
        else $error("event output active while disabled");
    a_pad_gated: assert property (pad_out |-> event_out && !pad_out_oe_b)
        else $error("pad data without drive or event");
    a_drive_enable: assert property (!pad_out_oe_b |-> comp_enable)
        else $error("pad driven while comparator off");
    a_pdown_off: assert property (sleep_mode == SLEEP_POWER_DOWN |->
        !comp_enable && pad_out_oe_b) else $error("active in power down");
    a_standby_quiet: assert property (sleep_mode == SLEEP_STANDBY &&
        !clk_per_running |-> !irq) else $error("irq in clockless standby");
    a_read_idle: assert property (!rd_q |-> hrdata == 32'h0000_0000)
        else $error("read data outside read data phase");
    a_irq_hold: assert property ($fell(irq) |-> $past(wr_q) ||
        (sleep_mode == SLEEP_STANDBY && !clk_per_running))
        else $error("irq dropped without a write");
    a_cfg_by_write: assert property ($changed({low_current_sel,
        hysteresis_sel, positive_input_sel, negative_input_sel}) |->
        $past(wr_q)) else $error("analog setting changed without write");
    c_irq: cover property ($rose(irq));
    c_pad: cover property (pad_out && !pad_out_oe_b);
    c_pdown: cover property (sleep_mode == SLEEP_POWER_DOWN);
endmodule : comparator_control_assertions
bind comparator_control_regs comparator_control_assertions i_chk (.*);
`default_nettype wire

//--- sim/comparator_control_regs_bench.sv
// self-checking bench of the comparator control block
`timescale 1ns/1ps
`default_nettype none
module comparator_control_regs_bench;
    import comparator_control_pkg::*;
    logic core_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, comp_raw = 0;
    logic clk_per_running = 0, rd_pend = 0, pin_req = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0, got, exp_v, q[$];
    logic [7:0] ctrl = 0, mux = 0;
    sleep_mode_t sleep_mode = SLEEP_ACTIVE;
    wire logic hreadyout, hresp, pad_out, pad_out_oe_b, event_out, irq;
    wire logic comp_enable, low_current_sel, positive_input_sel;
    wire logic [1:0] hysteresis_sel, negative_input_sel;
    wire logic [31:0] hrdata;
    wire logic hready = hreadyout; // single slave drives bus ready
    int mismatches = 0, checked = 0, seed = 73870;
    comparator_control_regs #(.SYNC_STAGES(3)) i_dut (.*);
    // ------------------------------------------------------------------
    // clock, bus tasks and monitor
    // ------------------------------------------------------------------
    initial forever #20 core_clk = ~core_clk;
    task automatic give_verdict;
        if (mismatches == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    // one single word transfer; held until ready is seen high
    task automatic xfer(input logic w, input logic [31:0] a, d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
    endtask : xfer
    task automatic rd(input logic [31:0] a, e);
        q.push_back(e);
        xfer(1'b0, a, 32'h0000_0000);
    endtask : rd
    // control at word index 0, mux at index 2, each in the low byte
    task automatic wr0;
        xfer(1'b1, 32'h0000_0000, {24'h00_0000, ctrl});
        xfer(1'b1, 32'h0000_0008, {24'h00_0000, mux});
    endtask : wr0
    // pin expectation from the register copies and the sleep state
    task automatic pins(input logic irq_e);
        logic en;
        logic ev;
        en = ctrl[0] && sleep_mode != SLEEP_POWER_DOWN &&
            (sleep_mode != SLEEP_STANDBY || ctrl[7]);
        ev = en && (comp_raw ^ mux[7]);
        q.push_back({21'h0, ctrl[2:1], mux[1:0], mux[3], ctrl[3], irq_e,
            ev && ctrl[6], !(en && ctrl[6]), ev, en});
        pin_req <= 1'b1;
        @(posedge core_clk);
        pin_req <= 1'b0;
    endtask : pins
    // results are taken in the data phase or at a pin sample request
    always @(posedge core_clk) begin
        if (rd_pend || pin_req) begin
            got = rd_pend ? hrdata : {21'h0, hysteresis_sel,
                negative_input_sel, positive_input_sel, low_current_sel,
                irq, pad_out, pad_out_oe_b, event_out, comp_enable};
            exp_v = q.pop_front();
            checked++;
            if (got !== exp_v) begin
                mismatches++;
                $display("ERROR %0t got %h exp %h", $time, got, exp_v);
            end
        end
        rd_pend <= hsel && htrans[1] && !hwrite && hready;
    end
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end
    initial begin
        tick(2);
        rst_b <= 1'b1;
        rd(32'h0000_0000, 32'h0000_0000);
        rd(32'h0000_0004, 32'h0000_0000);
        rd(32'h0000_000c, 32'h0000_0000);
        rd(32'h0000_0014, 32'h0000_0000);
        repeat (4) begin
            ctrl = 8'($random(seed));
            mux = 8'($random(seed));
            comp_raw <= 1'($random(seed));
            wr0();
            rd(32'h0000_0000, {24'h00_0000, ctrl});
            rd(32'h0000_0008, {24'h00_0000, mux & 8'h8b});
            pins(1'b0);
        end
        mux = 8'h00;
        for (int m = 0; m < 4; m++) begin
            comp_raw <= 1'b0;
            ctrl = {2'b00, 2'(m), 4'h1};
            wr0();
            tick(8);
            xfer(1'b1, 32'h0000_001c, 32'h0000_0001);
            comp_raw <= 1'b1;
            tick(8);
            rd(32'h0000_001c, {24'h00_0000, 7'h08, m == 0 || m == 3});
            xfer(1'b1, 32'h0000_001c, 32'h0000_0001);
            comp_raw <= 1'b0;
            tick(8);
            rd(32'h0000_001c, {24'h00_0000, 7'h00, m == 0 || m == 2});
        end
        mux = 8'h80;
        ctrl = 8'h71;
        wr0();
        tick(8);
        rd(32'h0000_001c, 32'h0000_0011);
        pins(1'b0);
        xfer(1'b1, 32'h0000_0018, 32'h0000_0001);
        rd(32'h0000_0018, 32'h0000_0001);
        rd(32'h0000_001c, 32'h0000_0011);
        xfer(1'b1, 32'h0000_0020, 32'h0000_0001);
        rd(32'h0000_0020, 32'h0000_0001);
        pins(1'b1);
        xfer(1'b1, 32'h0000_001c, 32'h0000_0001);
        rd(32'h0000_001c, 32'h0000_0010);
        pins(1'b0);
        // re-enabling the core below may set the flag; keep irq off there
        xfer(1'b1, 32'h0000_0018, 32'h0000_0000);
        for (int s = 0; s < 8; s++) begin
            sleep_mode <= sleep_mode_t'(s[1:0]);
            ctrl = {s[2], 7'h71};
            wr0();
            pins(1'b0);
        end
        sleep_mode <= SLEEP_ACTIVE;
        xfer(1'b1, 32'h0000_0018, 32'h0000_0001);
        ctrl = 8'hc1;
        wr0();
        tick(8);
        xfer(1'b1, 32'h0000_001c, 32'h0000_0001);
        sleep_mode <= SLEEP_STANDBY;
        tick(2);
        comp_raw <= 1'b1;
        tick(8);
        pins(1'b0);
        comp_raw <= 1'b0;
        tick(8);
        sleep_mode <= SLEEP_ACTIVE;
        tick(8);
        rd(32'h0000_001c, 32'h0000_0010);
        tick(2);
        give_verdict();
    end
endmodule : comparator_control_regs_bench
`default_nettype wire
